// ---- dv/usb_device_port_regs_asserts.sv ----
// port checker of the usb port register bank
module usb_device_port_regs_chk #(
  parameter SUSPEND_CYCLES = 20
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire bus_activity,
  input wire bus_reset_done_stb,
  input wire ep_traffic_en,
  input wire address_state_flag,
  input wire configured_state_flag,
  input wire [6:0] bus_address_value,
  input wire suspend_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int idle_cnt;
  // saturates so a long idle spell cannot wrap
  always @(posedge aclk)
    if (!aresetn || bus_activity)
      idle_cnt <= 0;
    else if (idle_cnt < 1000)
      idle_cnt <= idle_cnt + 1;
  property p_addr_hold;
    $fell(address_state_flag) |-> $past(bus_reset_done_stb);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address flag dropped");
  property p_conf_src;
    $changed(configured_state_flag) |-> $rose(s_axi_bvalid) || $past(bus_reset_done_stb);
  endproperty
  a_conf_src: assert property (p_conf_src) else $error("configured flag moved");
  property p_addr_val;
    $changed(bus_address_value) |-> $rose(s_axi_bvalid);
  endproperty
  a_addr_val: assert property (p_addr_val) else $error("bus address moved");
  property p_fen_src;
    $changed(ep_traffic_en) |-> $rose(s_axi_bvalid);
  endproperty
  a_fen_src: assert property (p_fen_src) else $error("enable moved");
  property p_susp_late;
    $rose(suspend_mode) |-> idle_cnt >= SUSPEND_CYCLES - 2;
  endproperty
  a_susp_late: assert property (p_susp_late) else $error("suspend too early");
  property p_susp_due;
    idle_cnt >= SUSPEND_CYCLES + 3 |-> suspend_mode;
  endproperty
  a_susp_due: assert property (p_susp_due) else $error("suspend missing");
  property p_susp_wake;
    bus_activity |-> ##[1:2] !suspend_mode;
  endproperty
  a_susp_wake: assert property (p_susp_wake) else $error("suspend kept");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  c_susp: cover property ($rose(suspend_mode));
  c_conf: cover property ($rose(configured_state_flag));
  c_addr: cover property ($fell(address_state_flag));
endmodule // usb_device_port_regs_chk
bind usb_device_port_regs usb_device_port_regs_chk #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .bus_activity,
  .bus_reset_done_stb, .ep_traffic_en, .address_state_flag, .configured_state_flag,
  .bus_address_value, .suspend_mode);

// ---- dv/usb_device_port_regs_test.sv ----
// testbench of the usb port register bank
module usb_device_port_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0, aresetn = 1'h0, go = 1'h0, bad = 1'h0, idle = 1'h0;
  logic bus_reset_done_stb = 1'h0, resume_stb = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [10:0] frame = 11'h000, sof_frame_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, suspend_mode;
  logic sof_pid_stb, sof_eop_stb, sof_crc_err, bus_activity, ep_traffic_en;
  logic address_state_flag, configured_state_flag;
  logic [6:0] bus_address_value;
  logic wakeup_stb = 1'h0, txv_disable;
  logic [5:0] ep_reset_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, checks_done = 0;
  usb_device_port_regs #(.SUSPEND_CYCLES(20)) usb_device_port_regs_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sof_pid_stb, .sof_eop_stb,
    .sof_crc_err, .sof_frame_in, .bus_activity, .bus_reset_done_stb, .resume_stb,
    .wakeup_stb, .ep_irq_in(6'h00), .ep_traffic_en, .address_state_flag,
    .configured_state_flag, .bus_address_value, .suspend_mode, .txv_disable, .ep_reset_out);
  usb_host_model usb_host_model_i (.aclk, .go, .bad, .idle, .frame, .sof_pid_stb,
    .sof_eop_stb, .sof_crc_err, .sof_frame_in, .bus_activity);
  initial forever #4 aclk = ~aclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bready stays high, so each write ends on its response edge
  // no cycle limit here: only the watchdog ends a wait
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    chk(s_axi_bresp, 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, 32'h0);
  endtask
  task sof(input logic [10:0] f, input logic b);
    frame <= f;
    bad <= b;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    @(posedge aclk);
  endtask
  task bus_reset;
    bus_reset_done_stb <= 1'h1;
    resume_stb <= 1'h1;
    wakeup_stb <= 1'h1;
    @(posedge aclk);
    bus_reset_done_stb <= 1'h0;
    resume_stb <= 1'h0;
    wakeup_stb <= 1'h0;
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h100);
    rd(8'h18, 32'h1200);
    rd(8'h0C, 32'h0);
    rd(8'h74, 32'h100);
    chk(txv_disable, 32'h1);
    $display("reset values done");
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h18, 32'h3B3F);
    wr(8'h14, 32'h1201);
    rd(8'h18, 32'h393E);
    wr(8'h10, 32'h0);
    rd(8'h18, 32'h393E);
    $display("irq mask done");
    bus_reset();
    rd(8'h18, 32'h1200);
    rd(8'h1C, 32'h3200);
    wr(8'h20, 32'h3B00);
    rd(8'h1C, 32'h0);
    wr(8'h08, 32'hFFFFFEFF);
    chk(ep_traffic_en, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h17F);
    chk(ep_traffic_en, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h3);
    rd(8'h04, 32'h3);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h1);
    chk({address_state_flag, configured_state_flag, bus_address_value}, 32'h17F);
    $display("device state done");
    sof(11'h5A5, 1'h0);
    rd(8'h1C, 32'h800);
    rd(8'h00, 32'h0);
    repeat (14) @(posedge aclk);
    rd(8'h00, 32'h205A5);
    sof(11'h2C3, 1'h1);
    rd(8'h00, 32'h5A5);
    repeat (14) @(posedge aclk);
    rd(8'h00, 32'h102C3);
    $display("frame capture done");
    idle <= 1'h1;
    repeat (30) @(posedge aclk);
    chk(suspend_mode, 32'h1);
    rd(8'h1C, 32'h900);
    idle <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(suspend_mode, 32'h0);
    bus_reset();
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h17F);
    $display("suspend and bus reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h30 + 8'(4 * i), 32'(i + 1));
      wr(8'h50 + 8'(4 * i), 32'(i + 16));
    end
    wr(8'h70, 32'hFFFF);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'h30 + 8'(4 * i), 32'(i + 1));
      rd(8'h50 + 8'(4 * i), 32'(i + 16));
    end
    rd(8'h70, 32'h0);
    rd(8'h48, 32'h0);
    wr(8'h74, 32'h0);
    chk(txv_disable, 32'h0);
    wr(8'h28, 32'h3F);
    rd(8'h28, 32'h3F);
    chk(ep_reset_out, 32'h3F);
    $display("endpoint map done");
    summarize();
  end
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    summarize();
  end
endmodule // usb_device_port_regs_test

// ---- dv/usb_host_model.sv ----
// far-side host model: frame-start packets and bus idle
module usb_host_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic bad,
  input wire logic idle,
  input wire logic [10:0] frame,
  output logic sof_pid_stb,
  output logic sof_eop_stb,
  output logic sof_crc_err,
  output logic [10:0] sof_frame_in,
  output logic bus_activity
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic err_r = 1'h0;
  logic [10:0] frm_r = 11'h000;
  assign sof_crc_err = err_r;
  assign sof_frame_in = frm_r;
  // eop trails pid by 12 cycles so a read fits in between
  always @(posedge aclk)
  begin
    sof_pid_stb <= go;
    sof_eop_stb <= (cnt == 1);
    cnt <= go ? 12 : (cnt > 0 ? cnt - 1 : 0);
    // outside eop the lines toggle, never hold stale data
    err_r <= (cnt == 1) ? bad : ~err_r;
    frm_r <= (cnt == 1) ? frame : ~frm_r;
  end
  assign bus_activity = !idle;
endmodule // usb_host_model

// ---- rtl/usb_device_port_regs.v ----
// usb full-speed device port register bank behind an axi4-lite slave
//
// Overview of operation
// - endpoint control/status registers from 0x030, word spaced
// - endpoint fifo data registers from 0x050, word spaced
// - load 11-bit frame index at frame packet end
// - frame error flag bit 16, cleared at next pid
// - frame good flag bit 17, cleared at next pid
// - frame-start interrupt raised at pid, not end
// - address flag: write 1 enters, 0 ignored
// - configured flag: write 1 enters, 0 leaves
// - 7-bit bus address, zero after reset
// - function enable bit 8 gates endpoint traffic
// - enable register: write 1 enables source
// - disable register: write 1 disables source
// - 3ms idle raises suspend interrupt, enters suspend
// - mask bit 12 unmaskable, always reads one
//
// Implementation choice: the AXI4-Lite register port.
`include "usb_port_regs_defines.vh"
module usb_device_port_regs #(
  parameter SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sof_pid_stb,
  input wire sof_eop_stb,
  input wire sof_crc_err,
  input wire [10:0] sof_frame_in,
  input wire bus_activity,
  input wire bus_reset_done_stb,
  input wire resume_stb,
  input wire wakeup_stb,
  input wire [5:0] ep_irq_in,
  output reg ep_traffic_en,
  output reg address_state_flag,
  output reg configured_state_flag,
  output reg [6:0] bus_address_value,
  output reg suspend_mode,
  output reg txv_disable,
  output reg [5:0] ep_reset_out
);

  // ****************************************
  // functions
  // ****************************************
  function [31:0] merge_bytes;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      merge_bytes = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // binary endpoint index, 6 means no endpoint register hit
  function [2:0] ep_index;
    input [7:0] addr;
    input [7:0] base;
    reg [7:0] diff;
    begin
      diff = addr - base;
      if (addr >= base && diff[7:2] < 6'h06)
        ep_index = diff[4:2];
      else
        ep_index = 3'h6;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [10:0] frame_r;
  reg sof_error_flag_r;
  reg sof_good_flag_r;
  reg [31:0] irq_mask_r;
  reg [31:0] irq_sticky_r;
  reg [31:0] ep_csr_r [0:5];
  reg [31:0] ep_fifo_r [0:5];
  reg [31:0] txv_r;
  reg [31:0] suspend_cnt_r;
  reg [7:0] aw_addr_r;
  reg aw_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_held_r;
  integer k;
  localparam [31:0] FADDR_RST_VAL = `RST_FUNC_ADDRESS;

  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [7:0] wa = {aw_addr_r[7:2], 2'b00};
  wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wbits = w_data_r & wmask;
  wire [2:0] w_csr_ix = ep_index(wa, `OFS_EP_CSR_BASE);
  wire [2:0] w_fifo_ix = ep_index(wa, `OFS_EP_FIFO_BASE);
  wire [31:0] irq_status = irq_sticky_r | {26'h0, ep_irq_in};
  wire suspend_hit = (suspend_cnt_r == SUSPEND_CYCLES - 1);

  // ****************************************
  // axi write channel
  // ****************************************
  // address and data are taken independently; ready drops while one is held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  reg [31:0] rd_val;
  reg [2:0] r_csr_ix;
  reg [2:0] r_fifo_ix;
  always @*
  begin
    rd_val = 32'h0000_0000;
    r_csr_ix = ep_index({s_axi_araddr[7:2], 2'b00}, `OFS_EP_CSR_BASE);
    r_fifo_ix = ep_index({s_axi_araddr[7:2], 2'b00}, `OFS_EP_FIFO_BASE);
    case ({s_axi_araddr[7:2], 2'b00})
      `OFS_FRAME_NUMBER: rd_val = {14'h0, sof_good_flag_r, sof_error_flag_r, 5'h00, frame_r};
      `OFS_DEVICE_STATE: rd_val = {30'h0, configured_state_flag, address_state_flag};
      `OFS_FUNC_ADDRESS: rd_val = {23'h0, ep_traffic_en, 1'b0, bus_address_value};
      `OFS_IRQ_MASK: rd_val = irq_mask_r | (32'h1 << `IRQ_BUSRES_BIT);
      `OFS_IRQ_STATUS: rd_val = irq_status;
      `OFS_EP_RESET: rd_val = {26'h0, ep_reset_out};
      `OFS_TXV_CTRL: rd_val = txv_r;
      default: rd_val = 32'h0000_0000;
    endcase
    if (r_csr_ix != 3'h6)
      rd_val = ep_csr_r[r_csr_ix];
    if (r_fifo_ix != 3'h6)
      rd_val = ep_fifo_r[r_fifo_ix];
  end

  // read data is captured at the address handshake, answered one cycle later
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= 2'b00;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // frame number capture
  // ****************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_r <= 11'h000;
      sof_error_flag_r <= 1'b0;
      sof_good_flag_r <= 1'b0;
    end
    else if (sof_eop_stb)
    begin
      frame_r <= sof_frame_in;
      sof_error_flag_r <= sof_crc_err;
      sof_good_flag_r <= !sof_crc_err;
    end
    else if (sof_pid_stb)
    begin
      sof_error_flag_r <= 1'b0;
      sof_good_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // device state and function address
  // ****************************************
  // a bus reset drops the device back to default state; the address survives
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      address_state_flag <= 1'b0;
      configured_state_flag <= 1'b0;
      bus_address_value <= 7'h00;
      ep_traffic_en <= FADDR_RST_VAL[`FEN_BIT];
    end
    else
    begin
      if (bus_reset_done_stb)
      begin
        address_state_flag <= 1'b0;
        configured_state_flag <= 1'b0;
      end
      else if (do_write && wa == `OFS_DEVICE_STATE && w_strb_r[0])
      begin
        if (w_data_r[`ADDR_STATE_BIT])
          address_state_flag <= 1'b1;
        configured_state_flag <= w_data_r[`CONF_STATE_BIT];
      end
      if (do_write && wa == `OFS_FUNC_ADDRESS)
      begin
        if (w_strb_r[0])
          bus_address_value <= w_data_r[6:0];
        if (w_strb_r[1])
          ep_traffic_en <= w_data_r[`FEN_BIT];
      end
    end
  end

  // ****************************************
  // interrupt mask and status
  // ****************************************
  // hardware sets win over a clear written in the same cycle
  reg [31:0] set_ev;
  always @*
  begin
    set_ev = 32'h0000_0000;
    set_ev[`IRQ_SOF_BIT] = sof_pid_stb;
    set_ev[`IRQ_SUSPEND_BIT] = suspend_hit && !suspend_mode;
    set_ev[`IRQ_RESUME_BIT] = resume_stb;
    set_ev[`IRQ_BUSRES_BIT] = bus_reset_done_stb;
    set_ev[`IRQ_WAKEUP_BIT] = wakeup_stb;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask_r <= `RST_IRQ_MASK;
      irq_sticky_r <= 32'h0000_0000;
    end
    else
    begin
      if (bus_reset_done_stb)
        irq_mask_r <= `RST_IRQ_MASK;
      else if (do_write && wa == `OFS_IRQ_ENABLE)
        irq_mask_r <= irq_mask_r | (wbits & `IRQ_MASKABLE);
      else if (do_write && wa == `OFS_IRQ_DISABLE)
        irq_mask_r <= irq_mask_r & ~(wbits & `IRQ_MASKABLE);
      if (do_write && wa == `OFS_IRQ_CLEAR)
        irq_sticky_r <= (irq_sticky_r & ~(wbits & `IRQ_CLEARABLE)) | set_ev;
      else
        irq_sticky_r <= irq_sticky_r | set_ev;
    end
  end

  // ****************************************
  // suspend detection
  // ****************************************
  // any bus activity restarts the idle count and leaves suspend
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      suspend_cnt_r <= 32'h0000_0000;
      suspend_mode <= 1'b0;
    end
    else if (bus_activity)
    begin
      suspend_cnt_r <= 32'h0000_0000;
      suspend_mode <= 1'b0;
    end
    else if (suspend_hit)
      suspend_mode <= 1'b1;
    else
      suspend_cnt_r <= suspend_cnt_r + 32'h0000_0001;
  end

  // ****************************************
  // endpoint, endpoint reset and transceiver registers
  // ****************************************
  // endpoint control words are plain storage here; the endpoint engines own their meaning
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (k = 0; k < 6; k = k + 1)
      begin
        ep_csr_r[k] <= 32'h0000_0000;
        ep_fifo_r[k] <= 32'h0000_0000;
      end
      ep_reset_out <= 6'h00;
      txv_r <= `RST_TXV_CTRL;
      txv_disable <= 1'b1;
    end
    else
    begin
      if (bus_reset_done_stb)
      begin
        for (k = 0; k < 6; k = k + 1)
          ep_csr_r[k] <= 32'h0000_0000;
      end
      else if (do_write && w_csr_ix != 3'h6)
        ep_csr_r[w_csr_ix] <= merge_bytes(ep_csr_r[w_csr_ix], w_data_r, w_strb_r);
      if (do_write && w_fifo_ix != 3'h6)
        ep_fifo_r[w_fifo_ix] <= merge_bytes(ep_fifo_r[w_fifo_ix], w_data_r, w_strb_r);
      if (do_write && wa == `OFS_EP_RESET && w_strb_r[0])
        ep_reset_out <= w_data_r[5:0];
      if (do_write && wa == `OFS_TXV_CTRL)
      begin
        txv_r <= merge_bytes(txv_r, w_data_r, w_strb_r) & (32'h1 << `TXV_DISABLE_BIT);
        if (w_strb_r[1])
          txv_disable <= w_data_r[`TXV_DISABLE_BIT];
      end
    end
  end

endmodule // usb_device_port_regs

// ---- rtl/usb_port_regs_defines.vh ----
// register offsets, field positions, reset values and timing for the usb port registers
`ifndef USB_PORT_REGS_DEFINES_VH
`define USB_PORT_REGS_DEFINES_VH
// ****************************************
// offsets (byte addresses)
// ****************************************
`define OFS_FRAME_NUMBER 8'h00
`define OFS_DEVICE_STATE 8'h04
`define OFS_FUNC_ADDRESS 8'h08
`define OFS_IRQ_ENABLE 8'h10
`define OFS_IRQ_DISABLE 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_CLEAR 8'h20
`define OFS_EP_RESET 8'h28
`define OFS_EP_CSR_BASE 8'h30
`define OFS_EP_FIFO_BASE 8'h50
`define OFS_TXV_CTRL 8'h74
// ****************************************
// fields
// ****************************************
`define SOF_ERROR_FLAG_BIT 16
`define SOF_GOOD_FLAG_BIT 17
`define ADDR_STATE_BIT 0
`define CONF_STATE_BIT 1
`define FEN_BIT 8
`define IRQ_SUSPEND_BIT 8
`define IRQ_RESUME_BIT 9
`define IRQ_SOF_BIT 11
`define IRQ_BUSRES_BIT 12
`define IRQ_WAKEUP_BIT 13
`define IRQ_MASKABLE 32'h0000_2B3F
`define IRQ_CLEARABLE 32'h0000_3B00
`define TXV_DISABLE_BIT 8
// ****************************************
// reset values
// ****************************************
`define RST_FUNC_ADDRESS 32'h0000_0100
`define RST_IRQ_MASK 32'h0000_1200
`define RST_TXV_CTRL 32'h0000_0100
// ****************************************
// timing
// ****************************************
`define CLK_HZ 125000000
`define SUSPEND_IDLE_US 3000
`define SUSPEND_CYCLES ((`CLK_HZ / 1000000) * `SUSPEND_IDLE_US)
`endif
